// ===== hw/ssp_defs.vh
/*
  Constants of the synchronous slave serial port: register offsets, field
  positions, reset values, the implemented-bit mask and the receive FIFO depth.
  Assumes it is included by the port's design file and by its testbench.
*/
// Contract
// - Slave mode when port enable and clocked mode set, clock source clear.
// - Port transmits only while continuous and single receive enables are clear.
// - Transmission runs only while transmit enable is set.
// - Ninth-bit transmit option makes 9-bit characters; ninth bit written first.
// - Writing the transmit holding byte starts a character shifted by the master clock.
// - Transmit interrupt needs transmit, peripheral and global interrupt enables.
// - Continuous receive controls slave reception; receiver never idles while set.
// - Single receive enable has no effect in slave mode; the port still blocks transmission while it is set.
// - With continuous receive set, characters still complete and load during sleep.
// - Character completed in sleep raises receive interrupt and wakes the device.
// - Receive flag sets on each completed character; request only if enabled.
// - Ninth received bit shows in receive status; read before data byte.
// - Reading receive holding returns oldest byte and pops it from the FIFO.
// - Overrun stays until continuous receive or port enable clears; latter resets port.
// - Transmit status layout: clksrc, tx9, transmit_enable, sync, break, high_speed_baud_select, empty, bit9.
// - Unimplemented register bits read as zero.
// - Second held character moves to shifter later; transmit flag sets then.
// - Ninth received bit belongs to the top unread FIFO character.
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define SSP_OFF_BAUD 12'h000
`define SSP_OFF_RXSTA 12'h004
`define SSP_OFF_DIVLO 12'h008
`define SSP_OFF_DIVHI 12'h00c
`define SSP_OFF_TXHOLD 12'h010
`define SSP_OFF_TXSTA 12'h014
`define SSP_OFF_RXHOLD 12'h018
`define SSP_OFF_INTCTL 12'h01c
`define SSP_OFF_SLEEP 12'h020
`define SSP_TX_CLOCK_SOURCE_SELECT 7
`define SSP_TX_NINE 6
`define SSP_TX_EN 5
`define SSP_TX_SYNC 4
`define SSP_TX_BREAK 3
`define SSP_TX_HIGH_SPEED_BAUD_SELECT 2
`define SSP_TX_EMPTY 1
`define SSP_TX_BIT9 0
`define SSP_RX_PEN 7
`define SSP_RX_NINE 6
`define SSP_RX_SINGLE_RECEIVE_ENABLE 5
`define SSP_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define SSP_RX_ADDEN 3
`define SSP_RX_FRAMING_ERROR 2
`define SSP_RX_OVERRUN_ERROR 1
`define SSP_RX_BIT9 0
`define SSP_IC_GIE 0
`define SSP_IC_PEIE 1
`define SSP_IC_TXIE 2
`define SSP_IC_RXIE 3
`define SSP_IC_TXIF 4
`define SSP_IC_RXIF 5
`define SSP_BAUD_IMPL 8'hfb
`define SSP_RST_TXSTA 8'h02
`define SSP_RST_BYTE 8'h00
`define SSP_FIFO_DEPTH 2
`endif

// ===== hw/ssp_mem.v
/*
  Small receive character memory with registered read data.
  Assumes one writer and one reader on the same clock.
*/
module ssp_mem #(
  parameter WIDTH = 9,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // ssp_mem

// ===== hw/ssp_slave_port.v
/*
  Synchronous slave serial port with APB register access.
  Assumes an external master drives the serial clock pin; both pins are
  sampled on pclk through two flip-flops before use.
*/
`include "ssp_defs.vh"
module ssp_slave_port #(
  parameter FIFO_DEPTH = `SSP_FIFO_DEPTH
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out,
  output reg serial_clock_pin_oe,
  input wire serial_data_pin_in,
  output reg serial_data_pin_out,
  output reg serial_data_pin_oe,
  output reg irq_request,
  output reg wake_request
);
  reg [7:0] txsta;
  reg [7:0] rxsta_ctl;
  reg [7:0] baud;
  reg [7:0] div_lo;
  reg [7:0] div_hi;
  reg [3:0] intctl;
  reg sleep_mode;
  reg [7:0] tx_hold;
  reg tx_hold_bit9;
  reg tx_hold_full;
  reg [8:0] tx_shift;
  reg [3:0] tx_count;
  reg tx_busy;
  reg tx_flag;
  reg [8:0] rx_shift;
  reg [3:0] rx_count;
  reg overrun;
  reg [1:0] wr_ptr;
  reg [1:0] rd_ptr;
  reg [1:0] fill;
  reg ck_s1, ck_s2, ck_s3;
  reg dt_s1, dt_s2;
  wire [8:0] fifo_top;
  wire ce = clk_en;
  wire pen = rxsta_ctl[`SSP_RX_PEN];
  wire continuous_receive_enable = rxsta_ctl[`SSP_RX_CONTINUOUS_RECEIVE_ENABLE];
  wire single_receive_enable = rxsta_ctl[`SSP_RX_SINGLE_RECEIVE_ENABLE];
  wire slave_mode = pen & txsta[`SSP_TX_SYNC] & ~txsta[`SSP_TX_CLOCK_SOURCE_SELECT];
  wire tx_mode = slave_mode & ~continuous_receive_enable & ~single_receive_enable & txsta[`SSP_TX_EN];
  wire rx_mode = slave_mode & continuous_receive_enable;
  wire nine_tx = txsta[`SSP_TX_NINE];
  wire nine_rx = rxsta_ctl[`SSP_RX_NINE];
  wire ck_rise = ck_s2 & ~ck_s3;
  wire ck_fall = ~ck_s2 & ck_s3;
  wire [3:0] tx_len = nine_tx ? 4'h9 : 4'h8;
  wire [3:0] rx_len = nine_rx ? 4'h9 : 4'h8;
  wire rx_done = rx_mode & ck_fall & (rx_count == rx_len - 4'h1);
  wire fifo_full = (fill == FIFO_DEPTH);
  wire push = rx_done & ~fifo_full & ~overrun;
  wire acc = psel & penable;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire pop = rd_acc & (paddr == `SSP_OFF_RXHOLD) & (fill != 2'h0);
  wire tx_load = tx_mode & tx_hold_full & ~tx_busy;
  wire [7:0] rxsta_view = {rxsta_ctl[7:3], 1'b0, overrun, (fill != 2'h0) & fifo_top[8]};
  wire [7:0] txsta_view = {txsta[7:2], ~tx_busy & ~tx_hold_full, txsta[0]};
  wire rx_flag = (fill != 2'h0);
  wire rx_irq = rx_flag & intctl[`SSP_IC_RXIE] & intctl[`SSP_IC_PEIE];
  wire tx_irq = tx_flag & intctl[`SSP_IC_TXIE] & intctl[`SSP_IC_PEIE];

  function [7:0] reg_read;
    input [11:0] a;
    begin
      case (a)
        `SSP_OFF_BAUD: reg_read = baud & `SSP_BAUD_IMPL;
        `SSP_OFF_RXSTA: reg_read = rxsta_view;
        `SSP_OFF_DIVLO: reg_read = div_lo;
        `SSP_OFF_DIVHI: reg_read = div_hi;
        `SSP_OFF_TXSTA: reg_read = txsta_view;
        `SSP_OFF_RXHOLD: reg_read = fifo_top[7:0];
        `SSP_OFF_INTCTL: reg_read = {2'b00, rx_flag, tx_flag, intctl};
        `SSP_OFF_SLEEP: reg_read = {7'h00, sleep_mode};
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a <= `SSP_OFF_SLEEP) && (a[1:0] == 2'b00);
    end
  endfunction

  reg [1:0] next_rd;

  // The completed character: the last bit arrives on the data pin at the final fall.
  wire [8:0] rx_char = nine_rx ? {dt_s2, rx_shift[8:1]} : {1'b0, dt_s2, rx_shift[8:2]};

  ssp_mem #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(1)
  ) u_mem (
    .clk(pclk),
    .ce(ce),
    .wr_en(push),
    .wr_addr(wr_ptr[0]),
    .wr_data(rx_char),
    .rd_addr(next_rd[0]),
    .rd_data(fifo_top)
  );

  always @* begin
    next_rd = pop ? rd_ptr + 2'h1 : rd_ptr;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      dt_s1 <= 1'b0;
      dt_s2 <= 1'b0;
    end else if (ce) begin
      ck_s1 <= serial_clock_pin_in;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      dt_s1 <= serial_data_pin_in;
      dt_s2 <= dt_s1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
      if (psel & ~penable & ~pwrite) begin
        prdata <= {24'h000000, reg_read(paddr)};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txsta <= `SSP_RST_TXSTA;
      rxsta_ctl <= `SSP_RST_BYTE;
      baud <= `SSP_RST_BYTE;
      div_lo <= `SSP_RST_BYTE;
      div_hi <= `SSP_RST_BYTE;
      intctl <= 4'h0;
      sleep_mode <= 1'b0;
    end else if (ce) begin
      if (wr_acc & pready) begin
        case (paddr)
          `SSP_OFF_BAUD: baud <= pwdata[7:0];
          `SSP_OFF_RXSTA: rxsta_ctl <= {pwdata[7:3], 3'b000};
          `SSP_OFF_DIVLO: div_lo <= pwdata[7:0];
          `SSP_OFF_DIVHI: div_hi <= pwdata[7:0];
          `SSP_OFF_TXSTA: txsta <= {pwdata[7:2], 1'b0, pwdata[0]};
          `SSP_OFF_INTCTL: intctl <= pwdata[3:0];
          `SSP_OFF_SLEEP: sleep_mode <= pwdata[0];
          default: sleep_mode <= sleep_mode;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold <= 8'h00;
      tx_hold_bit9 <= 1'b0;
      tx_hold_full <= 1'b0;
      tx_shift <= 9'h000;
      tx_count <= 4'h0;
      tx_busy <= 1'b0;
      tx_flag <= 1'b1;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= 1'b0;
    end else if (ce) begin
      if (!pen) begin
        tx_hold_full <= 1'b0;
        tx_busy <= 1'b0;
        tx_flag <= 1'b1;
        serial_data_pin_oe <= 1'b0;
      end else begin
        if (wr_acc & pready & (paddr == `SSP_OFF_TXHOLD)) begin
          tx_hold <= pwdata[7:0];
          tx_hold_bit9 <= txsta[`SSP_TX_BIT9];
          tx_hold_full <= 1'b1;
          tx_flag <= 1'b0;
        end else if (tx_load) begin
          tx_hold_full <= 1'b0;
          tx_flag <= 1'b1;
        end
        if (tx_load) begin
          tx_shift <= {tx_hold_bit9, tx_hold};
          tx_count <= 4'h0;
          tx_busy <= 1'b1;
          serial_data_pin_out <= tx_hold[0];
        end else if (tx_busy & tx_mode & ck_fall) begin
          if (tx_count == tx_len - 4'h1) begin
            tx_busy <= 1'b0;
          end else begin
            tx_count <= tx_count + 4'h1;
            tx_shift <= {1'b0, tx_shift[8:1]};
            serial_data_pin_out <= tx_shift[1];
          end
        end
        serial_data_pin_oe <= tx_mode;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift <= 9'h000;
      rx_count <= 4'h0;
      overrun <= 1'b0;
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      fill <= 2'h0;
    end else if (ce) begin
      if (!pen) begin
        rx_count <= 4'h0;
        overrun <= 1'b0;
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        fill <= 2'h0;
      end else begin
        if (!continuous_receive_enable) begin
          overrun <= 1'b0;
          rx_count <= 4'h0;
        end else if (rx_mode & ck_fall) begin
          rx_shift <= {dt_s2, rx_shift[8:1]};
          rx_count <= rx_done ? 4'h0 : rx_count + 4'h1;
          if (rx_done & (fifo_full | overrun)) begin
            overrun <= 1'b1;
          end
        end
        if (push) begin
          wr_ptr <= (wr_ptr == FIFO_DEPTH - 1) ? 2'h0 : wr_ptr + 2'h1;
        end
        if (pop) begin
          rd_ptr <= (rd_ptr == FIFO_DEPTH - 1) ? 2'h0 : rd_ptr + 2'h1;
        end
        fill <= fill + {1'b0, push} - {1'b0, pop};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 1'b0;
      wake_request <= 1'b0;
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
    end else if (ce) begin
      irq_request <= (rx_irq | tx_irq) & intctl[`SSP_IC_GIE];
      wake_request <= sleep_mode & (rx_irq | tx_irq);
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
    end
  end
endmodule // ssp_slave_port

// ===== verification/ssp_ext_master.sv
/* Behavioural external master that clocks frames, least significant bit first.
   Assumes the bench resolves the shared data wire from the port's enable. */
module ssp_ext_master (
  output logic sclk,
  output logic sdo,
  input wire sdi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b1;
    sdo = 1'b0;
  end
  // The clock stands high between frames; a released data line shows the inverse.
  task automatic frame(input int n, input logic [8:0] w, output logic [8:0] r);
    r = 9'h000;
    sdo = w[0];
    for (int i = 0; i < n; i++) begin
      #100 r[i] = sdi;
      sclk = 1'b0;
      #100 sclk = 1'b1;
      sdo = (i + 1 < n) ? w[i + 1] : ~sdo;
    end
    #400;
  endtask
endmodule // ssp_ext_master

// ===== verification/ssp_slave_port_properties.sv
/* Port-level assertions of the slave serial port.
   Assumes clk_en is held high and APB offsets as the port decodes them. */
module ssp_slave_port_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire serial_clock_pin_in,
  input wire serial_clock_pin_oe,
  input wire serial_data_pin_out,
  input wire serial_data_pin_oe,
  input wire irq_request,
  input wire wake_request
);
  logic [1:0] ie;
  logic slp;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadows of the global and peripheral enables and the sleep bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie <= 2'b00;
      slp <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == 12'h01c) ie <= pwdata[1:0];
      if (paddr == 12'h020) slp <= pwdata[0];
    end
  end
  AST_CLOCK_NEVER_DRIVEN: assert property (!serial_clock_pin_oe)
    else $error("clock pin driven");
  AST_ONE_CYCLE_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_UNMAPPED_ERR: assert property (pready && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access accepted");
  AST_MAPPED_OK: assert property (pready && paddr <= 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  AST_IRQ_GATED: assert property (irq_request |-> ie == 2'b11 || $past(ie) == 2'b11)
    else $error("request without enables");
  AST_WAKE_IN_SLEEP: assert property (wake_request |-> slp || $past(slp))
    else $error("wake while awake");
  AST_DATA_ON_FALL: assert property (serial_data_pin_oe && $fell(serial_clock_pin_in)
    |-> $stable(serial_data_pin_out) ##1 $stable(serial_data_pin_out))
    else $error("data moved at clock fall");
endmodule // ssp_slave_port_checker
bind ssp_slave_port ssp_slave_port_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .serial_clock_pin_in(serial_clock_pin_in),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe), .irq_request(irq_request),
  .wake_request(wake_request));

// ===== verification/ssp_slave_port_tb.sv
/* Self-checking bench of the slave serial port with an external clock master.
   Assumes hw/ is on the include path. */
`include "ssp_defs.vh"
module ssp_slave_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, ck_oe, ck_out, d_out, d_oe, irq_request, wake_request, err;
  logic [8:0] got;
  wire m_sclk, m_sdo;
  wire sclk = ck_oe ? ck_out : m_sclk;
  wire sdata = d_oe ? d_out : m_sdo;
  int miscompares = 0;
  int total_checks = 0;
  always #12.5 pclk = ~pclk;
  ssp_slave_port dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_clock_pin_in(sclk),
    .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe), .serial_data_pin_in(sdata),
    .serial_data_pin_out(d_out), .serial_data_pin_oe(d_oe), .irq_request(irq_request),
    .wake_request(wake_request));
  ssp_ext_master master_u (.sclk(m_sclk), .sdo(m_sdo), .sdi(sdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic regs_at_reset;
    apb(1'b0, 12'h014, 0);
    chk(rd[7:0], `SSP_RST_TXSTA);
    apb(1'b0, 12'h000, 0);
    chk(rd[2], 1'b0);
    apb(1'b0, 12'h024, 0);
    chk(err, 1'b1);
  endtask
  task automatic send_nine;
    apb(1'b1, 12'h004, 32'h80);
    apb(1'b1, 12'h014, 32'h71);
    apb(1'b1, 12'h01c, 32'h07);
    apb(1'b1, 12'h010, 32'ha5);
    chk(d_oe, 1'b1);
    master_u.frame(9, 9'h000, got);
    chk(got, 9'h1a5);
    apb(1'b0, 12'h014, 0);
    chk(rd[1], 1'b1);
    chk(irq_request, 1'b1);
    apb(1'b1, 12'h01c, 32'h06);
    apb(1'b0, 12'h01c, 0);
    chk(irq_request, 1'b0);
  endtask
  task automatic send_two_asleep;
    apb(1'b1, 12'h014, 32'h30);
    apb(1'b1, 12'h010, 32'h3c);
    apb(1'b1, 12'h010, 32'hc3);
    apb(1'b1, 12'h020, 32'h01);
    apb(1'b0, 12'h01c, 0);
    chk(rd[4], 1'b0);
    chk(wake_request, 1'b0);
    master_u.frame(8, 9'h000, got);
    chk(got, 9'h03c);
    apb(1'b0, 12'h01c, 0);
    chk(rd[4], 1'b1);
    chk(wake_request, 1'b1);
    master_u.frame(8, 9'h000, got);
    chk(got, 9'h0c3);
    apb(1'b1, 12'h020, 32'h00);
  endtask
  task automatic receive_asleep;
    apb(1'b1, 12'h014, 32'h10);
    apb(1'b1, 12'h004, 32'hf0);
    apb(1'b1, 12'h01c, 32'h0a);
    apb(1'b1, 12'h020, 32'h01);
    master_u.frame(9, 9'h15a, got);
    chk(d_oe, 1'b0);
    chk(wake_request, 1'b1);
    chk(irq_request, 1'b0);
    apb(1'b1, 12'h01c, 32'h0b);
    apb(1'b0, 12'h004, 0);
    chk(rd[0], 1'b1);
    chk(irq_request, 1'b1);
    apb(1'b0, 12'h018, 0);
    chk(rd[7:0], 8'h5a);
    apb(1'b0, 12'h01c, 0);
    chk(rd[5], 1'b0);
    apb(1'b1, 12'h020, 32'h00);
  endtask
  task automatic overrun;
    apb(1'b1, 12'h004, 32'hb0);
    master_u.frame(8, 9'h011, got);
    master_u.frame(8, 9'h022, got);
    master_u.frame(8, 9'h033, got);
    apb(1'b0, 12'h004, 0);
    chk(rd[1], 1'b1);
    apb(1'b0, 12'h018, 0);
    chk(rd[7:0], 8'h11);
    apb(1'b0, 12'h018, 0);
    chk(rd[7:0], 8'h22);
    apb(1'b0, 12'h004, 0);
    chk(rd[1], 1'b1);
    apb(1'b1, 12'h004, 32'ha0);
    apb(1'b0, 12'h004, 0);
    chk(rd[1], 1'b0);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    regs_at_reset();
    send_nine();
    send_two_asleep();
    receive_asleep();
    overrun();
    give_verdict();
  end
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end
endmodule // ssp_slave_port_tb
